// *** rtmx_defs.svh ***
// Constants of the return and miscellaneous instruction execution block.
// Assumes one 250 MHz clock and a classic Wishbone register port.
//
// Contract
// - The configuration load copies the working register into the option register in one cycle and touches no flag.
// - The software reset resets the core state and clears the active-low reset instruction flag.
// - The interrupt return pops the return stack and loads the popped top into the program counter.
// - The interrupt return sets the global interrupt enable, bit 7 of the interrupt control register.
// - The interrupt return is one word, takes two cycles and changes no flag.
// - The subroutine return pops the stack into the program counter and keeps flags and interrupt enable.
// - The subroutine return takes two cycles.
`ifndef RTMX_DEFS_SVH
`define RTMX_DEFS_SVH

// ==========================================================
// Widths
`define RTMX_PC_W       15
`define RTMX_INSTR_W    14
`define RTMX_ADR_W      8

// ==========================================================
// Instruction encodings
`define RTMX_OP_IDLE    14'h0000
`define RTMX_OP_SWRST   14'h0001
`define RTMX_OP_SUBRET  14'h0008
`define RTMX_OP_IRQRET  14'h0009
`define RTMX_OP_OPTLD   14'h0062

// ==========================================================
// Register byte addresses
`define RTMX_A_WREG     8'h00
`define RTMX_A_OPT      8'h04
`define RTMX_A_IRQC     8'h08
`define RTMX_A_POWER_CONTROL_REG     8'h0C
`define RTMX_A_PC       8'h10
`define RTMX_A_PUSH     8'h14
`define RTMX_A_STAT     8'h18

// ==========================================================
// Fields and reset values
`define RTMX_GIE_BIT    7
`define RTMX_RI_N_BIT   2
`define RTMX_BUSY_BIT   8
`define RTMX_PC_RST     15'h0000
`define RTMX_PC_STEP    15'h0001
`define RTMX_W_RST      8'h00
`define RTMX_OPT_RST    8'hFF
`define RTMX_IRQC_RST   8'h00

`endif

// *** rtmx_pkg.sv ***
// Types of the return and miscellaneous instruction execution block.
// Assumes rtmx_defs.svh is on the include path.
`include "rtmx_defs.svh"

package rtmx_pkg;

  typedef enum logic [0:0] {
    RTMX_S_RUN   = 1'b0,
    RTMX_S_FLUSH = 1'b1
  } rtmx_state_t;

  // Core state that the instructions and software both reach
  typedef struct packed {
    logic [`RTMX_PC_W-1:0] pc;
    logic [7:0]            w;
    logic [7:0]            opt;
    logic [7:0]            irqc;
    logic                  ri_n;
  } rtmx_core_t;

endpackage

// *** rtmx_stack.sv ***
// Hardware return stack of the core, circular on over- and underflow.
// Assumes push and pop are never requested in the same cycle.
`include "rtmx_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module rtmx_stack #(
  parameter int DEPTH = 16,
  parameter int WIDTH = `RTMX_PC_W,
  parameter int PW    = $clog2(DEPTH)
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             clear_i,
  input  wire logic             push_i,
  input  wire logic [WIDTH-1:0] push_data_i,
  input  wire logic             pop_i,
  output logic      [WIDTH-1:0] top_o,
  output logic      [PW-1:0]    level_o
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    ptr_q;
  logic [PW-1:0]    ptr_d;
  logic [PW-1:0]    top_idx;

  // ==========================================================
  // Pointer
  always_comb begin
    top_idx = ptr_q - PW'(1);
    ptr_d   = ptr_q;
    if (clear_i) begin
      ptr_d = '0;
    end else if (pop_i) begin
      ptr_d = top_idx;
    end else if (push_i) begin
      ptr_d = ptr_q + PW'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptr_q <= '0;
    end else begin
      ptr_q <= ptr_d;
    end
  end

  // ==========================================================
  // Storage; no reset, a wrapped pop returns stale words
  always_ff @(posedge clk_i) begin
    if (push_i && !clear_i) begin
      mem[ptr_q] <= push_data_i;
    end
  end

  assign top_o   = mem[top_idx];
  assign level_o = ptr_q;

endmodule
`default_nettype wire

// *** rtmx_exec.sv ***
// Execution of idle, option load, software reset and the two returns.
// Assumes decode presents one instruction word with a valid level and
// holds it until instr_ready_o was high at a clock edge.
`include "rtmx_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module rtmx_exec
  import rtmx_pkg::*;
#(
  parameter int STACK_DEPTH = 16,
  parameter int SP_W        = $clog2(STACK_DEPTH)
) (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     instr_valid_i,
  input  wire logic [`RTMX_INSTR_W-1:0] instr_i,
  output logic                          instr_ready_o,
  output logic      [`RTMX_PC_W-1:0]    pc_o,
  output logic      [7:0]               option_reg_o,
  output logic                          global_irq_enable_o,
  output logic                          soft_reset_o,
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [`RTMX_ADR_W-1:0]   wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o
);

  localparam rtmx_core_t CORE_RST = '{
    pc:   `RTMX_PC_RST,
    w:    `RTMX_W_RST,
    opt:  `RTMX_OPT_RST,
    irqc: `RTMX_IRQC_RST,
    ri_n: 1'b1
  };

  function automatic logic op_is(input logic [`RTMX_INSTR_W-1:0] a,
                                 input logic [`RTMX_INSTR_W-1:0] b);
    op_is = (a == b);
  endfunction

  rtmx_state_t              state_q;
  rtmx_state_t              state_d;
  rtmx_core_t               core_q;
  rtmx_core_t               core_d;
  logic                     ready_q;
  logic                     ready_d;
  logic                     srst_q;
  logic                     srst_d;
  logic                     ack_q;
  logic                     ack_d;
  logic [31:0]              rdat_q;
  logic [31:0]              rdat_d;
  logic                     fire;
  logic                     wb_go;
  logic                     st_push;
  logic                     st_pop;
  logic                     st_clear;
  logic [`RTMX_PC_W-1:0]    st_top;
  logic [SP_W-1:0]          st_level;

  rtmx_stack #(
    .DEPTH (STACK_DEPTH),
    .WIDTH (`RTMX_PC_W),
    .PW    (SP_W)
  ) u_stack (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .clear_i     (st_clear),
    .push_i      (st_push),
    .push_data_i (wb_dat_i[`RTMX_PC_W-1:0]),
    .pop_i       (st_pop),
    .top_o       (st_top),
    .level_o     (st_level)
  );

  // ==========================================================
  // Instruction execution and register port
  // Bus accesses wait while an instruction is taken, so the two never
  // write the same state in one cycle.
  always_comb begin
    fire     = instr_valid_i && ready_q;
    wb_go    = wb_cyc_i && wb_stb_i && !ack_q && !fire;
    state_d  = state_q;
    core_d   = core_q;
    srst_d   = 1'b0;
    st_pop   = 1'b0;
    st_push  = 1'b0;
    st_clear = 1'b0;
    ack_d    = wb_go;
    rdat_d   = rdat_q;
    case (state_q)
      RTMX_S_RUN: begin
        if (fire) begin
          if (op_is(instr_i, `RTMX_OP_OPTLD)) begin
            core_d.opt = core_q.w;
            core_d.pc  = core_q.pc + `RTMX_PC_STEP;
          end else if (op_is(instr_i, `RTMX_OP_SWRST)) begin
            core_d      = CORE_RST;
            core_d.ri_n = 1'b0;
            srst_d      = 1'b1;
            st_clear    = 1'b1;
          end else if (op_is(instr_i, `RTMX_OP_IRQRET)) begin
            st_pop                       = 1'b1;
            core_d.pc                    = st_top;
            core_d.irqc[`RTMX_GIE_BIT]   = 1'b1;
            state_d                      = RTMX_S_FLUSH;
          end else if (op_is(instr_i, `RTMX_OP_SUBRET)) begin
            st_pop    = 1'b1;
            core_d.pc = st_top;
            state_d   = RTMX_S_FLUSH;
          end else begin
            // Idle and words owned by other units only step the counter
            core_d.pc = core_q.pc + `RTMX_PC_STEP;
          end
        end
      end
      RTMX_S_FLUSH: begin
        // Second cycle of a return: the fetched word is discarded
        state_d = RTMX_S_RUN;
      end
      default: begin
        state_d = RTMX_S_RUN;
      end
    endcase
    ready_d = (state_d == RTMX_S_RUN);
    if (wb_go) begin
      rdat_d = 32'h0000_0000;
      if (wb_adr_i == `RTMX_A_WREG) begin
        rdat_d[7:0] = core_q.w;
        if (wb_we_i && wb_sel_i[0]) begin
          core_d.w = wb_dat_i[7:0];
        end
      end else if (wb_adr_i == `RTMX_A_OPT) begin
        rdat_d[7:0] = core_q.opt;
      end else if (wb_adr_i == `RTMX_A_IRQC) begin
        rdat_d[7:0] = core_q.irqc;
        if (wb_we_i && wb_sel_i[0]) begin
          core_d.irqc = wb_dat_i[7:0];
        end
      end else if (wb_adr_i == `RTMX_A_POWER_CONTROL_REG) begin
        rdat_d[`RTMX_RI_N_BIT] = core_q.ri_n;
        // Software may only rearm the flag; hardware alone clears it
        if (wb_we_i && wb_sel_i[0] && wb_dat_i[`RTMX_RI_N_BIT]) begin
          core_d.ri_n = 1'b1;
        end
      end else if (wb_adr_i == `RTMX_A_PC) begin
        rdat_d[`RTMX_PC_W-1:0] = core_q.pc;
        if (wb_we_i && wb_sel_i[0]) begin
          core_d.pc[7:0] = wb_dat_i[7:0];
        end
        if (wb_we_i && wb_sel_i[1]) begin
          core_d.pc[`RTMX_PC_W-1:8] = wb_dat_i[`RTMX_PC_W-1:8];
        end
      end else if (wb_adr_i == `RTMX_A_PUSH) begin
        st_push = wb_we_i && (wb_sel_i[1:0] == 2'h3);
      end else if (wb_adr_i == `RTMX_A_STAT) begin
        rdat_d[SP_W-1:0]        = st_level;
        rdat_d[`RTMX_BUSY_BIT]  = (state_q == RTMX_S_FLUSH);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= RTMX_S_RUN;
      core_q  <= CORE_RST;
      ready_q <= 1'b1;
      srst_q  <= 1'b0;
      ack_q   <= 1'b0;
      rdat_q  <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      core_q  <= core_d;
      ready_q <= ready_d;
      srst_q  <= srst_d;
      ack_q   <= ack_d;
      rdat_q  <= rdat_d;
    end
  end

  assign instr_ready_o       = ready_q;
  assign pc_o                = core_q.pc;
  assign option_reg_o        = core_q.opt;
  assign global_irq_enable_o = core_q.irqc[`RTMX_GIE_BIT];
  assign soft_reset_o        = srst_q;
  assign wb_ack_o            = ack_q;
  assign wb_dat_o            = rdat_q;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic f_opt;
  logic f_rst;
  logic f_iret;
  logic f_sret;
  logic f_idle;
  assign f_opt  = fire && op_is(instr_i, `RTMX_OP_OPTLD);
  assign f_rst  = fire && op_is(instr_i, `RTMX_OP_SWRST);
  assign f_iret = fire && op_is(instr_i, `RTMX_OP_IRQRET);
  assign f_sret = fire && op_is(instr_i, `RTMX_OP_SUBRET);
  assign f_idle = fire && op_is(instr_i, `RTMX_OP_IDLE);

  AST_OPT_COPY: assert property (
    f_opt |=> core_q.opt == $past(core_q.w) && core_q.w == $past(core_q.w)
      && core_q.irqc == $past(core_q.irqc))
    else $error("Option load did not copy the working register");

  AST_OPT_ONE_CYCLE: assert property (
    f_opt |=> ready_q && pc_o == `RTMX_PC_W'($past(pc_o) + `RTMX_PC_STEP))
    else $error("Option load took more than one cycle");

  AST_SWRST: assert property (
    f_rst |=> soft_reset_o && !core_q.ri_n && pc_o == `RTMX_PC_RST
      && st_level == '0 ##1 !soft_reset_o)
    else $error("Software reset missing or flag not cleared");

  AST_IRET_PC: assert property (
    f_iret |=> pc_o == $past(st_top)
      && st_level == SP_W'($past(st_level) - SP_W'(1)))
    else $error("Interrupt return did not pop into the counter");

  AST_IRET_GIE: assert property (
    f_iret |=> global_irq_enable_o && option_reg_o == $past(option_reg_o))
    else $error("Interrupt return left interrupts disabled");

  AST_IRET_CYCLES: assert property (
    f_iret |=> !ready_q ##1 ready_q && pc_o == $past(pc_o))
    else $error("Interrupt return did not take two cycles");

  AST_SRET: assert property (
    f_sret |=> pc_o == $past(st_top)
      && global_irq_enable_o == $past(global_irq_enable_o)
      && st_level == SP_W'($past(st_level) - SP_W'(1)))
    else $error("Subroutine return popped wrongly");

  AST_SRET_CYCLES: assert property (
    f_sret |=> !ready_q ##1 ready_q)
    else $error("Subroutine return did not take two cycles");

  AST_IDLE: assert property (
    f_idle |=> ready_q && pc_o == `RTMX_PC_W'($past(pc_o) + `RTMX_PC_STEP)
      && core_q.w == $past(core_q.w) && option_reg_o == $past(option_reg_o)
      && st_level == $past(st_level))
    else $error("Idle instruction changed state");

  // ==========================================================
  // Sources of change
  // A taken word blocks the bus in its cycle, so a change seen right
  // after a taking edge can only come from the instruction itself.

  AST_OPT_SOURCE: assert property (
    !$past(rst_i) && $changed(option_reg_o) |-> $past(f_opt) || $past(f_rst))
    else $error("Option register changed without a load");

  AST_RIN_CLEAR: assert property (
    $fell(core_q.ri_n) |-> $past(f_rst))
    else $error("Reset flag cleared without a software reset");

  AST_SRST_SOURCE: assert property (
    soft_reset_o |-> $past(f_rst))
    else $error("Reset pulse without a software reset");

  AST_GIE_SOURCE: assert property (
    !$past(rst_i) && $past(fire) && $changed(global_irq_enable_o)
      |-> $past(f_iret) || $past(f_rst))
    else $error("Interrupt enable changed by a wrong instruction");

  AST_LEVEL_SOURCE: assert property (
    !$past(rst_i) && $past(fire) && st_level != $past(st_level)
      |-> $past(f_iret) || $past(f_sret) || $past(f_rst))
    else $error("Stack moved on an instruction that does not pop");

  AST_IRET_KEEP: assert property (
    f_iret |=> core_q.w == $past(core_q.w)
      && core_q.ri_n == $past(core_q.ri_n))
    else $error("Interrupt return changed other state");

  AST_SRET_KEEP: assert property (
    f_sret |=> core_q.w == $past(core_q.w)
      && option_reg_o == $past(option_reg_o))
    else $error("Subroutine return changed other state");

  COV_OPT: cover property (f_opt);
  COV_IRET: cover property (f_iret ##2 fire);
  COV_SRET: cover property (f_sret);
  COV_SWRST: cover property (f_rst);
  COV_WB_READ: cover property (wb_ack_o && !wb_we_i);

endmodule
`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench for the return and miscellaneous execution block.
// Assumes rtmx_pkg and rtmx_exec are compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import rtmx_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        instr_valid_i = 1'b0;
  logic [13:0] instr_i = 14'h0000;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic        instr_ready_o, global_irq_enable_o, soft_reset_o, wb_ack_o;
  logic [14:0] pc_o;
  logic [7:0]  option_reg_o;
  logic [31:0] wb_dat_o, rd;
  int          err_count = 0;
  int          samples_checked = 0;
  int          m_pc, m_w, m_opt, m_gie, a, b;
  int          stk[$];

  // ==========================================================
  // Clock, design
  always #2 clk_i = ~clk_i;

  rtmx_exec dut (
    .clk_i(clk_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .instr_ready_o(instr_ready_o), .pc_o(pc_o),
    .option_reg_o(option_reg_o),
    .global_irq_enable_o(global_irq_enable_o),
    .soft_reset_o(soft_reset_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o)
  );

  // ==========================================================
  // Tasks
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Classic cycle; ack and read data are taken at one rising edge,
  // and only after that edge is the request released
  task automatic wb(input logic we, input logic [7:0] adr,
                    input logic [3:0] sel, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= dat;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 100);
    if (wb_ack_o !== 1'b1) err_count++;
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  // Issue one word, update the model, compare the cycle after taking
  task automatic exec(input logic [13:0] op);
    int n;
    n = 0;
    @(posedge clk_i);
    instr_valid_i <= 1'b1;
    instr_i       <= op;
    do begin
      @(posedge clk_i);
      n++;
    end while (instr_ready_o !== 1'b1 && n < 100);
    if (instr_ready_o !== 1'b1) err_count++;
    instr_valid_i <= 1'b0;
    case (op)
      14'h0062: begin m_opt = m_w; m_pc = (m_pc + 1) & 32'h7FFF; end
      14'h0009: begin m_pc = stk.pop_back(); m_gie = 1; end
      14'h0008: m_pc = stk.pop_back();
      14'h0001: begin
        m_pc = 0; m_w = 0; m_opt = 8'hFF; m_gie = 0; stk.delete();
      end
      default: m_pc = (m_pc + 1) & 32'h7FFF;
    endcase
    @(negedge clk_i);
    chk(pc_o, m_pc);
    chk(option_reg_o, m_opt);
    chk(global_irq_enable_o, m_gie);
    chk(soft_reset_o, op == 14'h0001);
    // A return holds the port for its second cycle
    chk(instr_ready_o, !(op == 14'h0008 || op == 14'h0009));
  endtask

  // ==========================================================
  // Watchdog, sized well above the hundred or so cycles used
  initial begin
    #40000;
    err_count++;
    finish_test();
  end

  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'h54C1));
    m_pc = 0; m_w = 0; m_opt = 8'hFF; m_gie = 0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk(pc_o, 0);
    chk(option_reg_o, 8'hFF);
    chk(instr_ready_o, 1);
    wb(1'b0, 8'h0C, 4'h1, 0); chk(rd[2], 1'b1);
    wb(1'b0, 8'h30, 4'h1, 0); chk(rd, 0);
    $display("test reset done");

    for (int i = 0; i < 3; i++) begin
      m_w = $urandom & 8'hFF;
      wb(1'b1, 8'h00, 4'h1, m_w);
      exec(14'h0062);
      wb(1'b0, 8'h00, 4'h1, 0); chk(rd[7:0], m_w);
    end
    $display("test option load done");

    exec(14'h0000);
    exec(14'h0000);
    exec(14'h1234);
    // A bus access raised with a taken word waits for the next cycle
    fork
      exec(14'h0000);
      wb(1'b0, 8'h04, 4'h1, 0);
    join
    chk(rd[7:0], m_opt);
    $display("test idle done");

    a = $urandom & 32'h7FFF;
    b = $urandom & 32'h7FFF;
    wb(1'b1, 8'h14, 4'h3, a); stk.push_back(a);
    wb(1'b1, 8'h14, 4'h3, b); stk.push_back(b);
    wb(1'b0, 8'h18, 4'h3, 0); chk(rd[3:0], 2);
    wb(1'b1, 8'h08, 4'h1, 0);
    exec(14'h0009);
    wb(1'b0, 8'h18, 4'h3, 0); chk(rd[3:0], 1);
    wb(1'b0, 8'h08, 4'h1, 0); chk(rd[7], 1'b1);
    wb(1'b1, 8'h08, 4'h1, 0); m_gie = 0;
    exec(14'h0008);
    wb(1'b0, 8'h18, 4'h3, 0); chk(rd[3:0], 0);
    $display("test returns done");

    wb(1'b1, 8'h10, 4'h3, 32'h0155); m_pc = 32'h0155;
    m_w = $urandom & 8'hFF;
    wb(1'b1, 8'h00, 4'h1, m_w);
    exec(14'h0062);
    exec(14'h0001);
    @(negedge clk_i); chk(soft_reset_o, 0);
    wb(1'b0, 8'h0C, 4'h1, 0); chk(rd[2], 1'b0);
    wb(1'b0, 8'h00, 4'h1, 0); chk(rd[7:0], 0);
    $display("test software reset done");
    finish_test();
  end
endmodule

`default_nettype wire
